// [prmi_params.svh]
/*
 * Offsets, field positions, reset values of the mode/init control block.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
`ifndef PRMI_PARAMS_SVH
`define PRMI_PARAMS_SVH

`define PRMI_OFF_CTRL0 8'h00
`define PRMI_OFF_PDIR 8'h04
`define PRMI_OFF_VTB_BASE 8'h08
`define PRMI_OFF_VTB_LIM 8'h0c
`define PRMI_OFF_GTB_BASE 8'h10
`define PRMI_OFF_GTB_LIM 8'h14
`define PRMI_OFF_STATUS 8'h18
`define PRMI_OFF_FETCH 8'h1c
`define PRMI_OFF_CONFIG 8'h20

`define PRMI_PROT_BIT 0
`define PRMI_PAGING_BIT 31
`define PRMI_ST_PROT 0
`define PRMI_ST_PAGING 1
`define PRMI_ST_PRIV_LO 2
`define PRMI_ST_NMI 4
`define PRMI_ST_PGREJ 5
`define PRMI_CFG_LARGE 0

`define PRMI_FETCH_RST 32'h0fff_fff0
`define PRMI_VTB_BASE_RST 32'h0000_0000
`define PRMI_LIM_RST 16'hffff
`define PRMI_PDIR_RST 32'h0000_0000

`endif

// [prmi_pkg.sv]
/*
 * Types shared by the mode/init control block.
 * Assumes nothing beyond the params header.
 */
package prmi_pkg;

    typedef struct packed {
        logic protMode;
        logic pagingOn;
        logic [1:0] privLevel;
    } prmi_mode_s;

    typedef struct packed {
        logic [31:0] base;
        logic [15:0] limit;
    } prmi_tbl_s;

    typedef enum logic {
        NMI_IDLE,
        NMI_BUSY
    } prmi_nmi_e;

    typedef logic [1:0] prmi_walk_t;

endpackage

// [prmi_nmi.sv]
/*
 * Nonmaskable interrupt acceptance: synchronises the pin, takes a falling
 * edge, blocks new ones while a handler runs.
 * Assumes the core pulses nmiDone on return from the handler.
 */
`timescale 1ns/10ps
module prmi_nmi
    import prmi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic nmiPin_n,
    input wire logic nmiDone,
    output logic nmiTake,
    output logic nmiBusy
);
    logic syncA_r, syncB_r, syncC_r;
    logic syncA_nxt, syncB_nxt, syncC_nxt;
    prmi_nmi_e state_r, state_nxt;
    logic take_r, take_nxt;
    logic edgeSeen;

    // syncA_r feeds only syncB_r
    always_comb begin
        syncA_nxt = nmiPin_n;
        syncB_nxt = syncA_r;
        syncC_nxt = syncB_r;
        edgeSeen = syncC_r & ~syncB_r;
        state_nxt = state_r;
        take_nxt = 1'b0;
        case (state_r)
            NMI_IDLE: begin
                if (edgeSeen) begin
                    take_nxt = 1'b1;
                    state_nxt = NMI_BUSY;
                end
            end
            // nested requests dropped, not queued
            NMI_BUSY: begin
                if (nmiDone) begin
                    state_nxt = NMI_IDLE;
                end
            end
            default: state_nxt = NMI_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            syncA_r <= 1'b1;
            syncB_r <= 1'b1;
            syncC_r <= 1'b1;
            state_r <= NMI_IDLE;
            take_r <= 1'b0;
        end else begin
            syncA_r <= syncA_nxt;
            syncB_r <= syncB_nxt;
            syncC_r <= syncC_nxt;
            state_r <= state_nxt;
            take_r <= take_nxt;
        end
    end

    assign nmiTake = take_r;
    assign nmiBusy = (state_r == NMI_BUSY);

    property p_nmi_accept;
        @(posedge ref_clk) disable iff (sys_rst)
        (edgeSeen && state_r == NMI_IDLE) |=> nmiTake && nmiBusy;
    endproperty
    a_nmi_accept: assert property (p_nmi_accept) else $error("idle nmi edge not taken");

    property p_nmi_block;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_r == NMI_BUSY) |=> !nmiTake;
    endproperty
    a_nmi_block: assert property (p_nmi_block) else $error("nmi taken while busy");
endmodule

// [prmi_ctrl.sv]
/*
 * Reset-time and operating-mode control: control register zero, page
 * directory pointer, vector and global table registers, reset fetch address,
 * NMI acceptance, all reached over APB.
 * Assumes the core pulses instrBoundary between instructions and nmiDone on
 * leaving the NMI handler; any external NMI gate sits ahead of nmiPin_n.
 */
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "prmi_params.svh"
module prmi_ctrl
    import prmi_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instrBoundary,
    input wire logic nmiPin_n,
    input wire logic nmiDone,
    output logic nmiTake,
    output logic startFetch,
    output logic [31:0] fetchAddr,
    output prmi_mode_s modeState,
    output prmi_tbl_s vecTable,
    output prmi_tbl_s globalTable,
    output logic [31:0] pageDirPtr,
    output prmi_walk_t walkLevels
);
    prmi_mode_s mode_r, mode_nxt;
    logic reqProt_r, reqProt_nxt;
    logic reqPaging_r, reqPaging_nxt;
    logic [31:0] pdir_r, pdir_nxt;
    prmi_tbl_s vtb_r, vtb_nxt;
    prmi_tbl_s gtb_r, gtb_nxt;
    logic [15:0] vtbLim_r, vtbLim_nxt;
    logic [15:0] gtbLim_r, gtbLim_nxt;
    logic large_r, large_nxt;
    logic pagingRej_r, pagingRej_nxt;
    logic rstDly_r, rstDly_nxt;
    logic startFetch_r, startFetch_nxt;
    logic [31:0] fetch_r, fetch_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic nmiBusy;
    logic wrEn;
    logic setup;

    function automatic logic addrHit(input logic [ADDR_W-1:0] a);
        case (a)
            `PRMI_OFF_CTRL0, `PRMI_OFF_PDIR, `PRMI_OFF_VTB_BASE, `PRMI_OFF_VTB_LIM,
            `PRMI_OFF_GTB_BASE, `PRMI_OFF_GTB_LIM, `PRMI_OFF_STATUS, `PRMI_OFF_FETCH,
            `PRMI_OFF_CONFIG: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    endfunction

    function automatic prmi_walk_t walkDepth(input logic paging, input logic largeOnly);
        if (!paging) begin
            walkDepth = 2'h0;
        end else if (largeOnly) begin
            walkDepth = 2'h1;
        end else begin
            walkDepth = 2'h2;
        end
    endfunction

    prmi_nmi u_nmi (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .nmiPin_n(nmiPin_n),
        .nmiDone(nmiDone),
        .nmiTake(nmiTake),
        .nmiBusy(nmiBusy)
    );

    // zero wait states; read data caught in the setup cycle
    assign setup = psel & ~penable;
    assign wrEn = psel & penable & pwrite & addrHit(paddr);

    always_comb begin
        mode_nxt = mode_r;
        reqProt_nxt = reqProt_r;
        reqPaging_nxt = reqPaging_r;
        pdir_nxt = pdir_r;
        vtb_nxt = vtb_r;
        gtb_nxt = gtb_r;
        vtbLim_nxt = vtbLim_r;
        gtbLim_nxt = gtbLim_r;
        large_nxt = large_r;
        pagingRej_nxt = pagingRej_r;
        rstDly_nxt = 1'b0;
        startFetch_nxt = rstDly_r;
        fetch_nxt = fetch_r;
        rdata_nxt = rdata_r;
        err_nxt = err_r;

        if (wrEn) begin
            case (paddr)
                `PRMI_OFF_CTRL0: begin
                    reqProt_nxt = pwdata[`PRMI_PROT_BIT];
                    reqPaging_nxt = pwdata[`PRMI_PAGING_BIT] & pwdata[`PRMI_PROT_BIT];
                    if (pwdata[`PRMI_PAGING_BIT] && !pwdata[`PRMI_PROT_BIT]) begin
                        pagingRej_nxt = 1'b1;
                    end
                end
                `PRMI_OFF_PDIR: pdir_nxt = pwdata;
                `PRMI_OFF_VTB_BASE: begin
                    vtb_nxt.base = pwdata;
                    vtb_nxt.limit = vtbLim_r;
                end
                `PRMI_OFF_VTB_LIM: vtbLim_nxt = pwdata[15:0];
                `PRMI_OFF_GTB_BASE: begin
                    gtb_nxt.base = pwdata;
                    gtb_nxt.limit = gtbLim_r;
                end
                `PRMI_OFF_GTB_LIM: gtbLim_nxt = pwdata[15:0];
                `PRMI_OFF_STATUS: begin
                    if (pwdata[`PRMI_ST_PGREJ]) begin
                        pagingRej_nxt = 1'b0;
                    end
                end
                `PRMI_OFF_CONFIG: large_nxt = pwdata[`PRMI_CFG_LARGE];
                default: ;
            endcase
        end
        // set wins over a same-cycle clear
        if (wrEn && paddr == `PRMI_OFF_CTRL0 && pwdata[`PRMI_PAGING_BIT] && !pwdata[`PRMI_PROT_BIT]) begin
            pagingRej_nxt = 1'b1;
        end

        if (instrBoundary) begin
            mode_nxt.protMode = reqProt_r;
            mode_nxt.pagingOn = reqPaging_r & reqProt_r;
            if (reqProt_r && !mode_r.protMode) begin
                mode_nxt.privLevel = 2'h0;
            end
            if (!reqProt_r) begin
                mode_nxt.privLevel = 2'h0;
            end
        end

        if (setup) begin
            err_nxt = ~addrHit(paddr);
            rdata_nxt = 32'h0000_0000;
            case (paddr)
                `PRMI_OFF_CTRL0: begin
                    rdata_nxt[`PRMI_PROT_BIT] = reqProt_r;
                    rdata_nxt[`PRMI_PAGING_BIT] = reqPaging_r;
                end
                `PRMI_OFF_PDIR: rdata_nxt = pdir_r;
                `PRMI_OFF_VTB_BASE: rdata_nxt = vtb_r.base;
                `PRMI_OFF_VTB_LIM: rdata_nxt[15:0] = vtbLim_r;
                `PRMI_OFF_GTB_BASE: rdata_nxt = gtb_r.base;
                `PRMI_OFF_GTB_LIM: rdata_nxt[15:0] = gtbLim_r;
                `PRMI_OFF_STATUS: begin
                    rdata_nxt[`PRMI_ST_PROT] = mode_r.protMode;
                    rdata_nxt[`PRMI_ST_PAGING] = mode_r.pagingOn;
                    rdata_nxt[`PRMI_ST_PRIV_LO+1:`PRMI_ST_PRIV_LO] = mode_r.privLevel;
                    rdata_nxt[`PRMI_ST_NMI] = nmiBusy;
                    rdata_nxt[`PRMI_ST_PGREJ] = pagingRej_r;
                end
                `PRMI_OFF_FETCH: rdata_nxt = fetch_r;
                `PRMI_OFF_CONFIG: rdata_nxt[`PRMI_CFG_LARGE] = large_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_r <= '0;
            reqProt_r <= 1'b0;
            reqPaging_r <= 1'b0;
            pdir_r <= `PRMI_PDIR_RST;
            vtb_r.base <= `PRMI_VTB_BASE_RST;
            vtb_r.limit <= `PRMI_LIM_RST;
            gtb_r.base <= 32'h0000_0000;
            gtb_r.limit <= `PRMI_LIM_RST;
            vtbLim_r <= `PRMI_LIM_RST;
            gtbLim_r <= `PRMI_LIM_RST;
            large_r <= 1'b0;
            pagingRej_r <= 1'b0;
            rstDly_r <= 1'b1;
            startFetch_r <= 1'b0;
            fetch_r <= `PRMI_FETCH_RST;
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            reqProt_r <= reqProt_nxt;
            reqPaging_r <= reqPaging_nxt;
            pdir_r <= pdir_nxt;
            vtb_r <= vtb_nxt;
            gtb_r <= gtb_nxt;
            vtbLim_r <= vtbLim_nxt;
            gtbLim_r <= gtbLim_nxt;
            large_r <= large_nxt;
            pagingRej_r <= pagingRej_nxt;
            rstDly_r <= rstDly_nxt;
            startFetch_r <= startFetch_nxt;
            fetch_r <= fetch_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    assign prdata = rdata_r;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_r;
    assign startFetch = startFetch_r;
    assign fetchAddr = fetch_r;
    assign modeState = mode_r;
    assign vecTable = vtb_r;
    assign globalTable = gtb_r;
    assign pageDirPtr = pdir_r;
    assign walkLevels = walkDepth(mode_r.pagingOn, large_r);

    sequence s_ctrlWrite(logic prot, logic paging);
        wrEn && paddr == `PRMI_OFF_CTRL0 && pwdata[`PRMI_PROT_BIT] == prot && pwdata[`PRMI_PAGING_BIT] == paging;
    endsequence

    sequence s_boundary;
        !instrBoundary ##1 instrBoundary;
    endsequence

    property p_reset_real;
        @(posedge ref_clk) $fell(sys_rst) |-> !modeState.protMode && !modeState.pagingOn
            && fetchAddr == 32'h0fff_fff0 && vecTable.base == 32'h0 ##1 startFetch ##1 !startFetch;
    endproperty
    a_reset_real: assert property (p_reset_real) else $error("reset state or fetch start wrong");

    property p_paging_needs_prot;
        @(posedge ref_clk) disable iff (sys_rst) modeState.pagingOn |-> modeState.protMode;
    endproperty
    a_paging_needs_prot: assert property (p_paging_needs_prot) else $error("paging on in real mode");

    property p_both_at_once;
        @(posedge ref_clk) disable iff (sys_rst)
        s_ctrlWrite(1'b1, 1'b1) ##0 !instrBoundary ##1 s_boundary |=> modeState.protMode && modeState.pagingOn;
    endproperty
    a_both_at_once: assert property (p_both_at_once) else $error("joint mode write not applied");

    property p_enter_prot;
        @(posedge ref_clk) disable iff (sys_rst) $rose(modeState.protMode) |-> modeState.privLevel == 2'h0;
    endproperty
    a_enter_prot: assert property (p_enter_prot) else $error("privilege not zero on entry");

    property p_only_at_boundary;
        @(posedge ref_clk) disable iff (sys_rst) !$past(instrBoundary) |-> $stable(modeState);
    endproperty
    a_only_at_boundary: assert property (p_only_at_boundary) else $error("mode moved off boundary");

    property p_back_to_real;
        @(posedge ref_clk) disable iff (sys_rst)
        s_ctrlWrite(1'b0, 1'b0) ##0 !instrBoundary ##1 s_boundary |=> !modeState.protMode && !modeState.pagingOn;
    endproperty
    a_back_to_real: assert property (p_back_to_real) else $error("clearing pe kept protected");

    property p_vtb_load;
        @(posedge ref_clk) disable iff (sys_rst)
        wrEn && paddr == `PRMI_OFF_VTB_BASE |=> vecTable.base == $past(pwdata) && vecTable.limit == $past(vtbLim_r);
    endproperty
    a_vtb_load: assert property (p_vtb_load) else $error("vector table load wrong");

    property p_gtb_load;
        @(posedge ref_clk) disable iff (sys_rst)
        wrEn && paddr == `PRMI_OFF_GTB_BASE |=> globalTable.base == $past(pwdata) && globalTable.limit == $past(gtbLim_r);
    endproperty
    a_gtb_load: assert property (p_gtb_load) else $error("global table load wrong");

    property p_walk_large;
        @(posedge ref_clk) disable iff (sys_rst) (modeState.pagingOn && large_r) |-> walkLevels == 2'h1;
    endproperty
    a_walk_large: assert property (p_walk_large) else $error("large pages still walk table");

    property p_pdir_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        wrEn && paddr == `PRMI_OFF_PDIR |=> pageDirPtr == $past(pwdata);
    endproperty
    a_pdir_hold: assert property (p_pdir_hold) else $error("directory pointer not loaded");
endmodule

// [prmi_core_model.sv]
/*
 * Far-side model: board NMI gate (AND with an I/O port flag) and an NMI
 * handler that returns a fixed time after acceptance.
 * Assumes the bench plays software: it raises the raw NMI and sets the flag.
 */
`timescale 1ns/10ps
module prmi_core_model #(
    parameter int HANDLER_CYC = 40
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic nmiRaw,
    input wire logic gateSet,
    input wire logic nmiTake,
    output logic nmiPin_n,
    output logic nmiDone
);
    logic gateOn_r = 1'b0;
    logic nmiDone_r = 1'b0;
    int handlerCnt = 0;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            gateOn_r <= 1'b0;
        end else if (gateSet) begin
            gateOn_r <= 1'b1;
        end
    end
    assign nmiPin_n = ~(nmiRaw & gateOn_r);

    // handler time kept long so nested requests land while busy
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            handlerCnt <= 0;
            nmiDone_r <= 1'b0;
        end else begin
            nmiDone_r <= (handlerCnt == 1);
            if (nmiTake === 1'b1) begin
                handlerCnt <= HANDLER_CYC;
            end else if (handlerCnt > 0) begin
                handlerCnt <= handlerCnt - 1;
            end
        end
    end
    assign nmiDone = nmiDone_r;
endmodule

// [prmi_ctrl_tb.sv]
/*
 * Self-checking bench for the mode/init control block over APB.
 * Assumes the far-side model for NMI gating and handler return.
 */
`timescale 1ns/10ps
`include "prmi_params.svh"
module prmi_ctrl_tb
    import prmi_pkg::*;
;
    logic ref_clk, sys_rst, psel, penable, pwrite, instrBoundary, nmiRaw, gateSet;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, fetchAddr, pageDirPtr, rdData;
    logic pready, pslverr, nmiPin_n, nmiDone, nmiTake, startFetch, rdErr;
    prmi_mode_s modeState;
    prmi_tbl_s vecTable, globalTable;
    prmi_walk_t walkLevels;
    int n_errors = 0;
    int n_checks = 0;
    int nFetch = 0;
    int nTakes = 0;

    prmi_ctrl #(.ADDR_W(8)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instrBoundary(instrBoundary), .nmiPin_n(nmiPin_n), .nmiDone(nmiDone),
        .nmiTake(nmiTake), .startFetch(startFetch), .fetchAddr(fetchAddr), .modeState(modeState),
        .vecTable(vecTable), .globalTable(globalTable), .pageDirPtr(pageDirPtr), .walkLevels(walkLevels));
    prmi_core_model #(.HANDLER_CYC(40)) model_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .nmiRaw(nmiRaw),
        .gateSet(gateSet), .nmiTake(nmiTake), .nmiPin_n(nmiPin_n), .nmiDone(nmiDone));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (startFetch === 1'b1) nFetch <= nFetch + 1;
        if (nmiTake === 1'b1) nTakes <= nTakes + 1;
    end

    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic boundary();
        @(posedge ref_clk);
        instrBoundary <= 1'b1;
        @(posedge ref_clk);
        instrBoundary <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic chk_mode(input logic p, input logic g);
        chk_bit(modeState.protMode, p);
        chk_bit(modeState.pagingOn, g);
        chk_word(32'(modeState.privLevel), 32'h0);
    endtask

    // raw request held a few cycles, then released so the pin returns high
    task automatic nmi_pulse(input int expTakes);
        @(posedge ref_clk);
        nmiRaw <= 1'b1;
        repeat (3) @(posedge ref_clk);
        nmiRaw <= 1'b0;
        repeat (8) @(negedge ref_clk);
        chk_word(32'(nTakes), 32'(expTakes));
    endtask

    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, instrBoundary, nmiRaw, gateSet} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk_word(32'(nFetch), 32'h1); // single start pulse
        chk_word(fetchAddr, 32'h0fff_fff0); // fetch address
        chk_mode(1'b0, 1'b0); // real mode, paging off
        chk_word(vecTable.base, 32'h0); // default base
        chk_word(32'(walkLevels), 32'h0); // no translation
        apb(1'b1, `PRMI_OFF_FETCH, 32'h0);
        apb(1'b0, `PRMI_OFF_FETCH, 32'h0);
        chk_word(rdData, 32'h0fff_fff0); // fetch register read-only
        apb(1'b1, 8'h24, 32'h1);
        chk_bit(rdErr, 1'b1);
        apb(1'b0, 8'h24, 32'h0);
        chk_word(rdData, 32'h0);
        // handler table kept below 1 MByte
        apb(1'b1, `PRMI_OFF_VTB_LIM, 32'h3ff);
        chk_word(32'(vecTable.limit), 32'hffff); // limit loads with base
        apb(1'b1, `PRMI_OFF_VTB_BASE, 32'h000f_0000);
        @(negedge ref_clk);
        chk_word(vecTable.base, 32'h000f_0000); // new base
        chk_word(32'(vecTable.limit), 32'h3ff); // limit
        // table at base holds null, code, data entries
        apb(1'b1, `PRMI_OFF_GTB_LIM, 32'h17);
        apb(1'b1, `PRMI_OFF_GTB_BASE, 32'h0002_0000);
        @(negedge ref_clk);
        chk_word(globalTable.base, 32'h0002_0000); // base
        chk_word(32'(globalTable.limit), 32'h17); // limit
        apb(1'b1, `PRMI_OFF_PDIR, 32'h0040_0000);
        @(negedge ref_clk);
        chk_word(pageDirPtr, 32'h0040_0000); // directory base
        apb(1'b1, `PRMI_OFF_CTRL0, 32'h8000_0000);
        boundary();
        chk_mode(1'b0, 1'b0); // paging refused alone
        apb(1'b0, `PRMI_OFF_STATUS, 32'h0);
        chk_bit(rdData[5], 1'b1); // refusal flagged
        apb(1'b1, `PRMI_OFF_STATUS, 32'h20);
        apb(1'b0, `PRMI_OFF_STATUS, 32'h0);
        chk_bit(rdData[5], 1'b0); // flag cleared
        apb(1'b1, `PRMI_OFF_CTRL0, 32'h1);
        repeat (3) @(negedge ref_clk);
        chk_mode(1'b0, 1'b0); // waits for boundary
        boundary();
        chk_mode(1'b1, 1'b0); // protected at level 0
        apb(1'b1, `PRMI_OFF_CTRL0, 32'h0);
        boundary();
        chk_mode(1'b0, 1'b0); // back to real mode
        apb(1'b1, `PRMI_OFF_CTRL0, 32'h8000_0001);
        boundary();
        chk_mode(1'b1, 1'b1); // both in one write
        chk_word(32'(walkLevels), 32'h2); // two-level walk
        apb(1'b1, `PRMI_OFF_CONFIG, 32'h1);
        @(negedge ref_clk);
        chk_word(32'(walkLevels), 32'h1); // directory only
        apb(1'b0, `PRMI_OFF_STATUS, 32'h0);
        chk_word(rdData & 32'h1f, 32'h03); // status view
        nmi_pulse(0); // gate still closed
        @(posedge ref_clk);
        gateSet <= 1'b1;
        @(posedge ref_clk);
        gateSet <= 1'b0;
        nmi_pulse(1); // accepted
        apb(1'b0, `PRMI_OFF_STATUS, 32'h0);
        chk_bit(rdData[4], 1'b1); // busy while serviced
        nmi_pulse(1); // nested one blocked
        repeat (40) @(posedge ref_clk);
        nmi_pulse(2); // accepted again after return
        // second reset from protected mode with paging on
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk_word(32'(nFetch), 32'h2); // fetch restarts once
        chk_mode(1'b0, 1'b0); // paging cleared by reset
        chk_word(vecTable.base, 32'h0); // base back to zero
        nmi_pulse(2); // gate closed again by reset
        stop_test();
    end

    // whole sequence takes well under 1500 cycles
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end
endmodule
